// ---- logic/scq_pkg.sv ----
// Purpose: constants, types and register map of the sync check output qualifier
// Assumes: 25 MHz clock, one program cycle per output time step
// Notes: byte addresses of the register words below
package scq_pkg;
    localparam int CLK_MHZ          = 25;
    localparam int PROG_CYCLE_US    = 5000;
    localparam int TICK_CLKS        = PROG_CYCLE_US * CLK_MHZ;
    localparam int STEP_MS          = 5;
    localparam int DEF_DELAY_MS     = 50;
    localparam int DEF_PULSE_MS     = 50;
    localparam int STEP_W           = 19;
    localparam int NSTAGE           = 3;
    localparam int ADDR_W           = 5;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADR_CTRL  = 5'h00;
    localparam logic [ADDR_W-1:0] ADR_DELAY = 5'h04;
    localparam logic [ADDR_W-1:0] ADR_PULSE = 5'h08;
    localparam logic [ADDR_W-1:0] ADR_LDSEL = 5'h0c;
    localparam logic [ADDR_W-1:0] ADR_STAT  = 5'h10;
    localparam logic [ADDR_W-1:0] ADR_IRQS  = 5'h14;
    localparam logic [ADDR_W-1:0] ADR_IRQM  = 5'h18;

    // control fields
    localparam int CTRL_MODE_LSB    = 0;
    localparam int CTRL_FEN_BIT     = 3;
    localparam int CTRL_FSEL_LSB    = 4;
    localparam int CTRL_REF_BIT     = 7;
    localparam int CTRL_OMODE_LSB   = 8;
    localparam int CTRL_GATE_LSB    = 10;
    localparam int CTRL_EN_LSB      = 14;
    localparam int LD_W             = 4;
    localparam int STAT_BLK_LSB     = 4;
    localparam int STAT_SMP_BIT     = 8;

    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0001_dfff;
    localparam logic [31:0] STEP_WMASK = 32'h0007_ffff;
    localparam logic [31:0] LD_WMASK   = 32'h0000_0fff;
    localparam logic [31:0] LD_RST     = 32'h0000_0000;
    localparam logic [31:0] IRQ_WMASK  = 32'h0000_0077;
    localparam logic [31:0] DELAY_RST  = 32'(DEF_DELAY_MS / STEP_MS);
    localparam logic [31:0] PULSE_RST  = 32'(DEF_PULSE_MS / STEP_MS);

    typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED,
                              MODE_OFF} scq_mode_t;
    typedef enum logic [2:0] {FRC_NORMAL, FRC_S1_BLK, FRC_S1_OK, FRC_S2_BLK, FRC_S2_OK,
                              FRC_S3_BLK, FRC_S3_OK} scq_force_t;
    typedef enum logic [1:0] {OUT_CONT, OUT_DLY_CONT, OUT_DLY_PULSE} scq_omode_t;
    typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_OK, ST_SPENT, ST_BLOCKED} scq_state_t;

    // live/dead combination masks: ref side first, measured side second
    localparam logic [3:0] LD_LL     = 4'h1;
    localparam logic [3:0] LD_LD     = 4'h2;
    localparam logic [3:0] LD_DL     = 4'h4;
    localparam logic [3:0] LD_DD     = 4'h8;
    localparam logic [3:0] LD_BYPASS = 4'ha;

    function automatic logic [3:0] ld_allowed(input logic [3:0] code);
        logic [3:0] m;
        m = LD_LL;
        case (code)
            4'h1: m = LD_LD;
            4'h2: m = LD_DL;
            4'h3: m = LD_LL | LD_LD;
            4'h4: m = LD_LL | LD_DL;
            4'h5: m = LD_LL | LD_DD;
            4'h6: m = LD_LL | LD_LD | LD_DL;
            4'h7: m = LD_LL | LD_LD | LD_DD;
            4'h8: m = LD_LL | LD_DL | LD_DD;
            4'h9: m = LD_LL | LD_LD | LD_DL | LD_DD;
            default: m = LD_LL;
        endcase
        return m;
    endfunction : ld_allowed

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask
endpackage : scq_pkg

// ---- logic/scq_top.sv ----
// Purpose: three stage sync check output qualifier with Avalon-MM registers
// Assumes: qualifier and block inputs come from logic on clk
// Notes: state advances on one program cycle tick
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module scq_top #(
    parameter int TICK_CLKS = scq_pkg::TICK_CLKS,
    parameter int STEP_W    = scq_pkg::STEP_W
) (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // avalon-mm slave
    input  wire logic [scq_pkg::ADDR_W-1:0]     avs_address,
    input  wire logic                           avs_read,
    input  wire logic                           avs_write,
    input  wire logic [31:0]                    avs_writedata,
    input  wire logic [3:0]                     avs_byteenable,
    output logic      [31:0]                    avs_readdata,
    output logic                                avs_waitrequest,
    // comparison results per stage
    input  wire logic [scq_pkg::NSTAGE-1:0]     mag_ok,
    input  wire logic [scq_pkg::NSTAGE-1:0]     freq_ok,
    input  wire logic [scq_pkg::NSTAGE-1:0]     ang_ok,
    input  wire logic [scq_pkg::NSTAGE-1:0]     bus_live,
    input  wire logic [scq_pkg::NSTAGE-1:0]     bus_dead,
    input  wire logic [scq_pkg::NSTAGE-1:0]     line_live,
    input  wire logic [scq_pkg::NSTAGE-1:0]     line_dead,
    input  wire logic [scq_pkg::NSTAGE-1:0]     stage_start_in,
    input  wire logic                           block_in,
    // qualified outputs
    output logic      [scq_pkg::NSTAGE-1:0]     sync_ok_out,
    output logic      [scq_pkg::NSTAGE-1:0]     blocked_out,
    output logic                                irq
);
    localparam int N  = scq_pkg::NSTAGE;
    localparam int TW = $clog2(TICK_CLKS + 1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [31:0]        ctrl_q;
    logic [31:0]        delay_q;
    logic [31:0]        pulse_q;
    logic [31:0]        ldsel_q;
    logic [31:0]        irq_stat_q;
    logic [31:0]        irq_stat_d;
    logic [31:0]        irq_mask_q;
    logic               wait_q;
    logic [31:0]        rd_mux;
    logic [31:0]        wmask;
    logic               wr_go;
    logic [TW-1:0]      tick_cnt_q;
    logic               tick_q;
    logic               proc_q;
    logic               blk_smp_q;
    scq_pkg::scq_mode_t  mode;
    scq_pkg::scq_omode_t omode;
    logic               run;
    logic               test_mode;
    logic               mode_blk;
    logic [N-1:0]       cond;
    logic [N-1:0]       ok_nxt;
    logic [N-1:0]       blk_nxt;
    logic [N-1:0]       st_ok;
    logic [N-1:0]       st_blk;
    logic [N-1:0]       stage_en;
    logic [N-1:0]       gate_sel;
    logic [STEP_W-1:0]  delay_steps;
    logic [STEP_W-1:0]  pulse_steps;
    scq_pkg::scq_state_t st_q [N];
    logic [STEP_W-1:0]  cnt_q [N];

    // mode decode, illegal codes act as off
    always_comb begin
        mode = scq_pkg::MODE_OFF;
        case (ctrl_q[scq_pkg::CTRL_MODE_LSB +: 3])
            3'h0:    mode = scq_pkg::MODE_ON;
            3'h1:    mode = scq_pkg::MODE_BLOCKED;
            3'h2:    mode = scq_pkg::MODE_TEST;
            3'h3:    mode = scq_pkg::MODE_TEST_BLOCKED;
            default: mode = scq_pkg::MODE_OFF;
        endcase
    end

    always_comb begin
        omode = scq_pkg::OUT_CONT;
        case (ctrl_q[scq_pkg::CTRL_OMODE_LSB +: 2])
            2'h1:    omode = scq_pkg::OUT_DLY_CONT;
            2'h2:    omode = scq_pkg::OUT_DLY_PULSE;
            default: omode = scq_pkg::OUT_CONT;
        endcase
    end

    assign run         = (mode != scq_pkg::MODE_OFF);
    assign test_mode   = (mode == scq_pkg::MODE_TEST) || (mode == scq_pkg::MODE_TEST_BLOCKED);
    assign mode_blk    = (mode == scq_pkg::MODE_BLOCKED) || (mode == scq_pkg::MODE_TEST_BLOCKED);
    assign stage_en    = ctrl_q[scq_pkg::CTRL_EN_LSB +: N];
    assign gate_sel    = ctrl_q[scq_pkg::CTRL_GATE_LSB +: N];
    assign delay_steps = delay_q[STEP_W-1:0];
    assign pulse_steps = pulse_q[STEP_W-1:0];

    // bus slave: one wait cycle, access completes when waitrequest is low
    assign wmask = scq_pkg::be_mask(avs_byteenable);
    assign wr_go = avs_write && !wait_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            scq_pkg::ADR_CTRL:  rd_mux = ctrl_q;
            scq_pkg::ADR_DELAY: rd_mux = delay_q;
            scq_pkg::ADR_PULSE: rd_mux = pulse_q;
            scq_pkg::ADR_LDSEL: rd_mux = ldsel_q;
            scq_pkg::ADR_STAT: begin
                rd_mux[N-1:0]                             = st_ok;
                rd_mux[scq_pkg::STAT_BLK_LSB +: N]        = st_blk;
                rd_mux[scq_pkg::STAT_SMP_BIT]             = blk_smp_q;
            end
            scq_pkg::ADR_IRQS:  rd_mux = irq_stat_q;
            scq_pkg::ADR_IRQM:  rd_mux = irq_mask_q;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wait_q       <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            wait_q <= !((avs_read || avs_write) && wait_q);
            if (avs_read && wait_q) begin
                avs_readdata <= rd_mux;
            end
        end
    end
    assign avs_waitrequest = wait_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q     <= scq_pkg::CTRL_RST;
            delay_q    <= scq_pkg::DELAY_RST;
            pulse_q    <= scq_pkg::PULSE_RST;
            ldsel_q    <= scq_pkg::LD_RST;
            irq_mask_q <= 32'h0000_0000;
        end else if (wr_go) begin
            case (avs_address)
                scq_pkg::ADR_CTRL:
                    ctrl_q <= (ctrl_q & ~wmask) | (avs_writedata & wmask & scq_pkg::CTRL_WMASK);
                scq_pkg::ADR_DELAY:
                    delay_q <= (delay_q & ~wmask) | (avs_writedata & wmask & scq_pkg::STEP_WMASK);
                scq_pkg::ADR_PULSE:
                    pulse_q <= (pulse_q & ~wmask) | (avs_writedata & wmask & scq_pkg::STEP_WMASK);
                scq_pkg::ADR_LDSEL:
                    ldsel_q <= (ldsel_q & ~wmask) | (avs_writedata & wmask & scq_pkg::LD_WMASK);
                scq_pkg::ADR_IRQM:
                    irq_mask_q <= (irq_mask_q & ~wmask) |
                                  (avs_writedata & wmask & scq_pkg::IRQ_WMASK);
                default: ;
            endcase
        end
    end

    // program cycle time base
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
            proc_q     <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TW'(TICK_CLKS - 1));
            proc_q <= tick_q;
            if (tick_cnt_q == TW'(TICK_CLKS - 1)) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + TW'(1);
            end
        end
    end

    // block sampled once per cycle, held for the whole cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            blk_smp_q <= 1'b0;
        end else if (tick_q) begin
            blk_smp_q <= block_in || mode_blk;
        end
    end

    a_block_sample: assert property (tick_q |=> blk_smp_q == ($past(block_in) || $past(mode_blk)))
        else $error("block not sampled at cycle start");
    a_block_held: assert property (!tick_q |=> $stable(blk_smp_q))
        else $error("sampled block changed inside a cycle");

    generate
        for (genvar i = 0; i < N; i++) begin : g_stage
            logic       ref_live;
            logic       ref_dead;
            logic       mea_live;
            logic       mea_dead;
            logic [3:0] ld_code;
            logic [3:0] allow;
            logic       v_ok;
            logic       frc_ok;
            logic       frc_blk;

            assign ref_live = ctrl_q[scq_pkg::CTRL_REF_BIT] ? bus_live[i] : line_live[i];
            assign ref_dead = ctrl_q[scq_pkg::CTRL_REF_BIT] ? bus_dead[i] : line_dead[i];
            assign mea_live = ctrl_q[scq_pkg::CTRL_REF_BIT] ? line_live[i] : bus_live[i];
            assign mea_dead = ctrl_q[scq_pkg::CTRL_REF_BIT] ? line_dead[i] : bus_dead[i];
            assign ld_code  = ldsel_q[i*scq_pkg::LD_W +: scq_pkg::LD_W];
            assign allow    = scq_pkg::ld_allowed(ld_code);
            assign v_ok     = (ld_code == scq_pkg::LD_BYPASS) ||
                              (allow[0] && ref_live && mea_live) ||
                              (allow[1] && ref_live && mea_dead) ||
                              (allow[2] && ref_dead && mea_live) ||
                              (allow[3] && ref_dead && mea_dead);
            assign cond[i]  = stage_en[i] && run &&
                              (!gate_sel[i] || stage_start_in[i]) &&
                              mag_ok[i] && freq_ok[i] && ang_ok[i] && v_ok;
            assign frc_blk  = ctrl_q[scq_pkg::CTRL_FEN_BIT] &&
                              (ctrl_q[scq_pkg::CTRL_FSEL_LSB +: 3] == 3'(2 * i + 1));
            assign frc_ok   = ctrl_q[scq_pkg::CTRL_FEN_BIT] &&
                              (ctrl_q[scq_pkg::CTRL_FSEL_LSB +: 3] == 3'(2 * i + 2));
            assign st_ok[i]   = (st_q[i] == scq_pkg::ST_OK);
            assign st_blk[i]  = (st_q[i] == scq_pkg::ST_BLOCKED);
            assign ok_nxt[i]  = stage_en[i] && (frc_ok || (!frc_blk && st_ok[i] && !test_mode));
            assign blk_nxt[i] = stage_en[i] && (frc_blk || (!frc_ok && st_blk[i]));

            always_ff @(posedge clk) begin
                if (srst || !stage_en[i] || !run) begin
                    st_q[i]  <= scq_pkg::ST_IDLE;
                    cnt_q[i] <= '0;
                end else if (proc_q) begin
                    unique case (st_q[i])
                        scq_pkg::ST_IDLE: begin
                            cnt_q[i] <= '0;
                            if (cond[i]) begin
                                if (omode == scq_pkg::OUT_DLY_CONT &&
                                    delay_steps != '0) begin
                                    st_q[i] <= scq_pkg::ST_DELAY;
                                end else if (blk_smp_q) begin
                                    st_q[i] <= scq_pkg::ST_BLOCKED;
                                end else begin
                                    st_q[i] <= scq_pkg::ST_OK;
                                end
                            end
                        end
                        scq_pkg::ST_DELAY: begin
                            if (!cond[i]) begin
                                st_q[i]  <= scq_pkg::ST_IDLE;
                                cnt_q[i] <= '0;
                            end else if (cnt_q[i] + STEP_W'(1) >= delay_steps) begin
                                cnt_q[i] <= '0;
                                st_q[i]  <= blk_smp_q ? scq_pkg::ST_BLOCKED :
                                                        scq_pkg::ST_OK;
                            end else begin
                                cnt_q[i] <= cnt_q[i] + STEP_W'(1);
                            end
                        end
                        scq_pkg::ST_OK: begin
                            if (!cond[i]) begin
                                st_q[i]  <= scq_pkg::ST_IDLE;
                                cnt_q[i] <= '0;
                            end else if (blk_smp_q) begin
                                st_q[i]  <= scq_pkg::ST_BLOCKED;
                            end else if (omode == scq_pkg::OUT_DLY_PULSE) begin
                                if (cnt_q[i] + STEP_W'(1) >= pulse_steps) begin
                                    st_q[i] <= scq_pkg::ST_SPENT;
                                end else begin
                                    cnt_q[i] <= cnt_q[i] + STEP_W'(1);
                                end
                            end
                        end
                        scq_pkg::ST_SPENT, scq_pkg::ST_BLOCKED: begin
                            if (!cond[i]) begin
                                st_q[i]  <= scq_pkg::ST_IDLE;
                                cnt_q[i] <= '0;
                            end
                        end
                    endcase
                end
            end

            sequence s_idle_ready;
                proc_q && st_q[i] == scq_pkg::ST_IDLE && cond[i] &&
                !(omode == scq_pkg::OUT_DLY_CONT && delay_steps != '0);
            endsequence
            sequence s_delay_run;
                proc_q && st_q[i] == scq_pkg::ST_DELAY && cond[i];
            endsequence

            a_ok_when_clear: assert property (s_idle_ready and (!blk_smp_q) |=>
                st_q[i] == scq_pkg::ST_OK ##1 sync_ok_out[i] ||
                test_mode || frc_blk || !stage_en[i])
                else $error("sync ok did not assert");
            a_blocked_instead: assert property (s_idle_ready and blk_smp_q |=>
                st_q[i] == scq_pkg::ST_BLOCKED)
                else $error("blocked indication missing");
            a_block_drops_ok: assert property (proc_q && st_ok[i] && cond[i] && blk_smp_q
                |=> !st_ok[i] ##1 (!sync_ok_out[i] || frc_ok))
                else $error("sync ok kept under block");
            a_delay_holds: assert property (s_delay_run and
                (cnt_q[i] + STEP_W'(1) < delay_steps) |=> st_q[i] == scq_pkg::ST_DELAY)
                else $error("delay ended early");
            a_pulse_ends: assert property (proc_q && st_ok[i] && cond[i] && !blk_smp_q &&
                omode == scq_pkg::OUT_DLY_PULSE && cnt_q[i] + STEP_W'(1) >= pulse_steps
                |=> st_q[i] == scq_pkg::ST_SPENT)
                else $error("pulse did not end");
            a_disabled_quiet: assert property (!stage_en[i] |=> st_q[i] == scq_pkg::ST_IDLE
                ##1 (!sync_ok_out[i] || stage_en[i]))
                else $error("disabled stage active");
            a_start_gates: assert property (proc_q && gate_sel[i] && !stage_start_in[i] &&
                st_q[i] == scq_pkg::ST_IDLE |=> st_q[i] == scq_pkg::ST_IDLE)
                else $error("gated stage ran without start");
            a_loss_restarts: assert property (proc_q && !cond[i] &&
                st_q[i] != scq_pkg::ST_IDLE |=> st_q[i] == scq_pkg::ST_IDLE && cnt_q[i] == '0)
                else $error("loss of sync not handled");
            a_force_ok: assert property (frc_ok && stage_en[i] |=> sync_ok_out[i])
                else $error("forced ok not shown");
        end
    endgenerate

    // qualified outputs and interrupt events
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_ok_out <= '0;
            blocked_out <= '0;
        end else begin
            sync_ok_out <= ok_nxt;
            blocked_out <= blk_nxt;
        end
    end

    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_go && avs_address == scq_pkg::ADR_IRQS) begin
            irq_stat_d = irq_stat_q & ~(avs_writedata & wmask);
        end
        irq_stat_d[N-1:0] = irq_stat_d[N-1:0] | (ok_nxt & ~sync_ok_out);
        irq_stat_d[scq_pkg::STAT_BLK_LSB +: N] = irq_stat_d[scq_pkg::STAT_BLK_LSB +: N] |
                                                 (blk_nxt & ~blocked_out);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat_q <= 32'h0000_0000;
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq        <= |(irq_stat_q & irq_mask_q);
        end
    end

    a_mode_reset: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> ctrl_q[scq_pkg::CTRL_MODE_LSB +: 3] == 3'h0 && stage_en == '0)
        else $error("mode not on after reset");
    a_off_idles: assert property (mode == scq_pkg::MODE_OFF |=> st_ok == '0 ##1
        (sync_ok_out == '0 || ctrl_q[scq_pkg::CTRL_FEN_BIT]))
        else $error("off mode still active");
endmodule : scq_top

// ---- test/scq_far.sv ----
// Purpose: blocking matrix model for the qualifier
// Assumes: one clock
// Notes: block level is changed only after a rising edge
`timescale 1ns/1ps
module scq_far (
    // clock and command
    input  wire logic clk,
    input  wire logic blk_req,
    // blocking output
    output logic      block_in
);
    always @(posedge clk) block_in <= blk_req;
endmodule : scq_far

// ---- test/testbench.sv ----
// Purpose: self-checking bench of the sync check output qualifier
// Assumes: program cycle shortened to 8 clocks
// Notes: expectations come from the register defaults and output rules
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
    logic clk = 0, srst = 1, rd = 0, wr = 0, blk = 0;
    logic [4:0] adr = 0;
    logic [31:0] wd = 0, rdat, q, rv;
    logic [2:0] cnd = 0, st = 0, so, bo;
    logic [2:0] bl = 3'h7, ll = 3'h7, mk = 3'h7, fk = 3'h7, ak = 3'h7;
    logic wq, irq, bi;
    int n_fail = 0, checks_done = 0;
    initial forever #20 clk = ~clk;
    scq_far u_far (.clk(clk), .blk_req(blk), .block_in(bi));
    scq_top #(.TICK_CLKS(8)) u_dut (.clk(clk), .srst(srst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
        .avs_readdata(rdat), .avs_waitrequest(wq), .mag_ok(cnd & mk), .freq_ok(cnd & fk),
        .ang_ok(cnd & ak), .bus_live(cnd & bl), .bus_dead(~(cnd & bl)), .line_live(cnd & ll),
        .line_dead(~(cnd & ll)), .stage_start_in(st), .block_in(bi), .sync_ok_out(so),
        .blocked_out(bo), .irq(irq));
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        adr <= a; wd <= d; rd <= !w; wr <= w;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat; rd <= 0; wr <= 0;
        @(posedge clk);
    endtask : bus
    task automatic ticks(input int n);
        repeat (n * 8) @(posedge clk);
    endtask : ticks
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    initial begin #(40 * 20000); n_fail++; finish_test; end
    initial begin
        void'($urandom(32'h302b));
        repeat (5) @(posedge clk);
        srst <= 0;
        bus(0, 5'h00, 0); `CHK(q, 32'h0000_0000)
        bus(0, 5'h04, 0); `CHK(q, 32'h0000_000a)
        bus(0, 5'h08, 0); `CHK(q, 32'h0000_000a)
        bus(0, 5'h1c, 0); `CHK(q, 32'h0000_0000)
        bus(0, 5'h10, 0); `CHK(q, 32'h0000_0000)
        rv = $urandom;
        bus(1, 5'h08, rv); bus(0, 5'h08, 0); `CHK(q, rv & 32'h0007_ffff)
        $display("test registers done");
        bus(1, 5'h18, 32'h0000_0011); bus(1, 5'h00, 32'h0000_4000);
        cnd <= 3'h7; ticks(4); `CHK(so, 3'b001)
        `CHK(irq, 1'b1)
        blk <= 1; ticks(3); `CHK({so, bo}, 6'b000_001)
        cnd <= 0; blk <= 0; bus(1, 5'h14, 32'h0000_0077); ticks(3);
        `CHK({so, bo, irq}, 7'b0)
        blk <= 1; ticks(2); cnd <= 3'h7; ticks(3); `CHK({so, bo}, 6'b000_001)
        cnd <= 0; blk <= 0; bus(1, 5'h00, 32'h0000_4400); ticks(3);
        cnd <= 3'h7; ticks(4); `CHK(so, 3'b000)
        st <= 3'h1; ticks(4); `CHK(so, 3'b001)
        $display("test gating done");
        cnd <= 0; bus(1, 5'h04, 3); bus(1, 5'h00, 32'h0000_4100); ticks(3);
        cnd <= 3'h7; ticks(2); `CHK(so, 3'b000)
        ticks(5); `CHK(so, 3'b001)
        bus(1, 5'h00, 32'h0000_4104); ticks(3); `CHK(so, 3'b000)
        $display("test delay done");
        cnd <= 0; bus(1, 5'h00, 32'h0000_4028); ticks(1); `CHK(so, 3'b001)
        bus(1, 5'h00, 32'h0000_4018); ticks(1); `CHK({so, bo}, 6'b000_001)
        bus(1, 5'h00, 32'h0000_4048); ticks(1); `CHK({so, bo}, 6'b000_000)
        bus(1, 5'h00, 32'h0000_4020); ticks(1); `CHK(so, 3'b000)
        $display("test force done");
        bus(1, 5'h00, 32'h0000_4002); cnd <= 3'h7; ticks(3); `CHK(so, 3'b000)
        bus(0, 5'h10, 0); `CHK(q[0], 1'b1)
        bus(1, 5'h00, 32'h0000_4001); ticks(3); `CHK({so, bo}, 6'b000_001)
        $display("test modes done");
        cnd <= 0; bus(1, 5'h08, 2); bus(1, 5'h00, 32'h0000_4200); ticks(2);
        cnd <= 3'h7;
        do @(posedge clk); while (so[0] !== 1'b1);
        ticks(1); `CHK(so, 3'b001)
        ticks(2); `CHK({so, bo}, 6'b000_000)
        $display("test pulse done");
        cnd <= 0; bl <= 3'h6; bus(1, 5'h0c, 1); bus(1, 5'h00, 32'h0000_4000); ticks(2);
        cnd <= 3'h7; ticks(3); `CHK(so, 3'b001)
        bus(1, 5'h00, 32'h0000_4080); ticks(3); `CHK(so, 3'b000)
        bus(1, 5'h0c, 2); ticks(3); `CHK(so, 3'b001)
        ll <= 3'h6; ticks(3); `CHK(so, 3'b000)
        bus(1, 5'h0c, 32'h0000_000a); ticks(3); `CHK(so, 3'b001)
        bl <= 3'h7; ll <= 3'h7; bus(1, 5'h0c, 0); fk <= 3'h6; ticks(3); `CHK(so, 3'b000)
        fk <= 3'h7; ak <= 3'h6; ticks(3); `CHK(so, 3'b000)
        ak <= 3'h7; mk <= 3'h6; ticks(3); `CHK(so, 3'b000)
        mk <= 3'h7; st <= 3'h0; ticks(3); `CHK(so, 3'b001)
        $display("test live dead done");
        finish_test;
    end
endmodule : testbench
